// ===== hdl/drive_cfg_pkg.sv
// Constants for the drive submode and feedback selection block.
// Assumes object dictionary accesses arrive decoded as index, subindex and data.
// Behaviour
// R1: Reboot only when the reboot command entry receives key 746f6f62.
// R2: Delay a requested reboot by the reboot delay entry, in milliseconds.
// R3: Submode bit 0 picks open loop (0) or closed loop (1).
// R4: Loop changeover is held off while operation enabled.
// R5: Submode bit 1 emulates velocity control with an S-ramp.
// R6: Submode bit 2 enables automatic holding brake control.
// R7: Submode bit 3 enables current reduction in open loop.
// R8: With bit 4, align in open loop after power-up, then close loop at once.
// R9: Without bit 4, stay open loop until the encoder index is seen.
// R10: A commutation encoder without index always forces auto alignment.
// R11: Bit 5 in torque modes makes torque control act alone.
// R12: Submode bit 6 marks the motor as brushless DC.
// R13: Bit 7 enables slow speed; master sets it only in closed loop.
// R14: Feedback mask writes during operation enabled apply on next entry to it.
// R15: Mask bit 0 position, bit 1 velocity, bit 2 commutation source.
// R16: Feedback count entry reports existing feedbacks, preset 3.
// R17: First mask entry is the always present sensorless feedback.
// R18: Each source search starts at sensor 2, ascending, first match wins.
// R19: With open loop selected the commutation bits are ignored.
// R20: Submode bits 8 to 31 are stored, read back, and do nothing.
package drive_cfg_pkg;

  // Object dictionary addresses
  localparam logic [15:0] OBJ_REBOOT = 16'h2800;
  localparam logic [15:0] OBJ_SUBMODE = 16'h3202;
  localparam logic [15:0] OBJ_FB_SEL = 16'h3203;
  localparam logic [7:0] SUB_COUNT = 8'h00;
  localparam logic [7:0] SUB_REBOOT_CMD = 8'h01;
  localparam logic [7:0] SUB_REBOOT_DELAY = 8'h02;

  // Key and reset values
  localparam logic [31:0] REBOOT_KEY = 32'h746f6f62;
  localparam logic [31:0] REBOOT_RESET = 32'h0000_0000;
  localparam logic [31:0] SUBMODE_RESET = 32'h0000_0000;
  localparam logic [7:0] FB_MASK_RESET = 8'h00;
  localparam int FB_COUNT_RESET = 3;

  // Submode bit positions
  localparam int SM_LOOP = 0;
  localparam int SM_RAMP = 1;
  localparam int SM_BRAKE = 2;
  localparam int SM_CURRENT_REDUCTION_EN = 3;
  localparam int SM_AUTO_ALIGNMENT_EN = 4;
  localparam int SM_TORQUE = 5;
  localparam int SM_BLDC = 6;
  localparam int SM_SLOW = 7;

  // Feedback mask bit positions and search
  localparam int FB_POS_BIT = 0;
  localparam int FB_VEL_BIT = 1;
  localparam int FB_COMM_BIT = 2;
  localparam int SEARCH_FIRST = 2;
  localparam logic [2:0] SENSOR_NONE = 3'h0;

  // Timing
  localparam int CLK_FREQ_HZ = 125000000;
  localparam int MS_PER_S = 1000;
  localparam int CYCLES_PER_MS = CLK_FREQ_HZ / MS_PER_S;

endpackage

// ===== hdl/feedback_source_search.sv
// Priority search that picks position, velocity and commutation sources.
// Assumes masks are already the applied copies; purely combinational.
`timescale 1ns/1ns
`default_nettype none

module feedback_source_search #(
  parameter int FB_COUNT = drive_cfg_pkg::FB_COUNT_RESET
) (
  input wire logic [FB_COUNT-1:0][7:0] masks,
  input wire logic loopClosedSel,
  output logic [2:0] posSource,
  output logic [2:0] velSource,
  output logic [2:0] commSource
);
  import drive_cfg_pkg::*;

  // First sensor from 2 upward with the bit set; the sensorless entry is never searched
  function automatic logic [2:0] first_set(input logic [FB_COUNT-1:0][7:0] m, input int b);
    logic [2:0] found;
    found = SENSOR_NONE;
    for (int s = FB_COUNT; s >= SEARCH_FIRST; s--) // [R17] [R18]
    begin
      if (m[s-1][b])
      begin
        found = 3'(s); // [R18]
      end
    end
    return found;
  endfunction

  // Commutation only means something in closed loop
  always_comb
  begin
    posSource = first_set(masks, FB_POS_BIT); // [R15]
    velSource = first_set(masks, FB_VEL_BIT); // [R15]
    commSource = loopClosedSel ? first_set(masks, FB_COMM_BIT) : SENSOR_NONE; // [R19]
  end

endmodule // feedback_source_search

`default_nettype wire

// ===== hdl/drive_submode_feedback_select.sv
// Submode word, reboot request and feedback selection for a motor drive.
// Assumes a fieldbus slave presents decoded dictionary accesses on mclk,
// and that the drive state machine reports operation enabled on mclk.
`timescale 1ns/1ns
`default_nettype none

module drive_submode_feedback_select #(
  parameter int FB_COUNT = drive_cfg_pkg::FB_COUNT_RESET,
  parameter int CYCLES_PER_MS_P = drive_cfg_pkg::CYCLES_PER_MS
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic odWrEn,
  input wire logic odRdEn,
  input wire logic [15:0] odIndex,
  input wire logic [7:0] odSubIndex,
  input wire logic [31:0] odWrData,
  output logic odAck,
  output logic odAbort,
  output logic [31:0] odRdData,
  input wire logic opEnabled,
  input wire logic torqueModeActive,
  input wire logic commNoIndex,
  input wire logic alignDone,
  input wire logic encIndexPin,
  output logic firmwareReboot,
  output logic rebootPending,
  output logic loopModeSelect,
  output logic closedLoopActive,
  output logic alignActive,
  output logic rampSpeedEmulation,
  output logic autoBrakeEn,
  output logic current_reduction_en,
  output logic torqueOnly,
  output logic bldcMotor,
  output logic slowSpeedEn,
  output logic [2:0] posSource,
  output logic [2:0] velSource,
  output logic [2:0] commSource
);
  import drive_cfg_pkg::*;

  localparam int CW = $clog2(CYCLES_PER_MS_P + 1);

  // Elaboration check: sensor numbers are three bits wide
  if (FB_COUNT < 1 || FB_COUNT > 7 || CYCLES_PER_MS_P < 1)
  begin : g_bad_param
    $error("drive_submode_feedback_select: unsupported parameter value");
  end

  typedef enum logic [1:0] {LOOP_OPEN, LOOP_ALIGN, LOOP_WAIT_INDEX, LOOP_CLOSED} loop_type;

  typedef struct packed {
    logic [31:0] submode;
    logic [FB_COUNT-1:0][7:0] mask;
    logic [FB_COUNT-1:0][7:0] maskApplied;
    logic [31:0] rebootCmd;
    logic [31:0] rebootDelay;
    logic rebootArmed;
    logic [31:0] msLeft;
    logic [CW-1:0] cycLeft;
    logic rebootPulse;
    logic loopApplied;
    loop_type loop;
    logic aligned;
    logic opEnPrev;
    logic [2:0] idxSync;
    logic ack;
    logic abort;
    logic [31:0] rdData;
    logic [2:0] pos;
    logic [2:0] vel;
    logic [2:0] comm;
  } state_type;

  state_type q;
  state_type d;
  logic [2:0] srchPos;
  logic [2:0] srchVel;
  logic [2:0] srchComm;
  logic idxEdge;
  logic fbSub;
  logic [2:0] fbSel;

  // Sources follow the applied masks, never the live ones
  feedback_source_search #(
    .FB_COUNT(FB_COUNT)
  ) u_search (
    .masks(q.maskApplied),
    .loopClosedSel(q.loopApplied),
    .posSource(srchPos),
    .velSource(srchVel),
    .commSource(srchComm)
  );

  // Rising edge of the index, read only from the second and third sync stages
  assign idxEdge = q.idxSync[1] & ~q.idxSync[2];
  assign fbSub = (odSubIndex >= 8'h01) && (odSubIndex <= 8'(FB_COUNT));
  assign fbSel = odSubIndex[2:0] - 3'h1;

  // Next-state logic; ce low leaves every field as it is
  always_comb
  begin
    d = q;
    if (ce)
    begin
      d.ack = 1'b0;
      d.abort = 1'b0;
      d.rebootPulse = 1'b0;
      d.opEnPrev = opEnabled;
      d.idxSync = {q.idxSync[1:0], encIndexPin};

      // Dictionary reads
      if (odRdEn)
      begin
        d.ack = 1'b1;
        d.rdData = 32'h0000_0000;
        if (odIndex == OBJ_SUBMODE && odSubIndex == SUB_COUNT)
        begin
          d.rdData = q.submode; // [R20]
        end
        else if (odIndex == OBJ_FB_SEL && odSubIndex == SUB_COUNT)
        begin
          d.rdData = 32'(FB_COUNT); // [R16]
        end
        else if (odIndex == OBJ_FB_SEL && fbSub)
        begin
          d.rdData = {24'h000000, q.mask[fbSel]};
        end
        else if (odIndex == OBJ_REBOOT && odSubIndex == SUB_REBOOT_CMD)
        begin
          d.rdData = q.rebootCmd;
        end
        else if (odIndex == OBJ_REBOOT && odSubIndex == SUB_REBOOT_DELAY)
        begin
          d.rdData = q.rebootDelay;
        end
        else
        begin
          d.ack = 1'b0;
          d.abort = 1'b1;
        end
      end
      // Dictionary writes; the count entry is read only
      else if (odWrEn)
      begin
        d.ack = 1'b1;
        if (odIndex == OBJ_SUBMODE && odSubIndex == SUB_COUNT)
        begin
          d.submode = odWrData; // [R20]
        end
        else if (odIndex == OBJ_FB_SEL && fbSub)
        begin
          d.mask[fbSel] = odWrData[7:0]; // [R14]
        end
        else if (odIndex == OBJ_REBOOT && odSubIndex == SUB_REBOOT_DELAY)
        begin
          d.rebootDelay = odWrData;
        end
        else if (odIndex == OBJ_REBOOT && odSubIndex == SUB_REBOOT_CMD)
        begin
          d.rebootCmd = odWrData;
          // Only the exact key arms; rewriting it restarts the delay
          if (odWrData == REBOOT_KEY)
          begin
            d.rebootArmed = 1'b1; // [R1]
            d.msLeft = q.rebootDelay; // [R2]
            d.cycLeft = CW'(CYCLES_PER_MS_P - 1);
          end
        end
        else
        begin
          d.ack = 1'b0;
          d.abort = 1'b1;
        end
      end

      // Millisecond countdown; zero delay reboots on the next cycle
      if (q.rebootArmed && !(odWrEn && odIndex == OBJ_REBOOT && odSubIndex == SUB_REBOOT_CMD))
      begin
        if (q.msLeft == 32'h0000_0000)
        begin
          d.rebootArmed = 1'b0;
          d.rebootPulse = 1'b1; // [R1]
        end
        else if (q.cycLeft == '0)
        begin
          d.msLeft = q.msLeft - 32'h0000_0001; // [R2]
          d.cycLeft = CW'(CYCLES_PER_MS_P - 1);
        end
        else
        begin
          d.cycLeft = q.cycLeft - CW'(1);
        end
      end

      // Loop selection takes effect only outside operation enabled
      if (!opEnabled)
      begin
        d.loopApplied = q.submode[SM_LOOP]; // [R3] [R4]
      end

      // Buffered masks are taken on entry to operation enabled
      if (opEnabled && !q.opEnPrev)
      begin
        d.maskApplied = q.mask; // [R14]
      end

      // Commutation state: alignment happens once after power-up
      case (q.loop)
        LOOP_OPEN:
        begin
          if (q.loopApplied)
          begin
            if (q.aligned)
            begin
              d.loop = LOOP_CLOSED;
            end
            else if (q.submode[SM_AUTO_ALIGNMENT_EN] || commNoIndex)
            begin
              d.loop = LOOP_ALIGN; // [R8] [R10]
            end
            else
            begin
              d.loop = LOOP_WAIT_INDEX; // [R9]
            end
          end
        end
        LOOP_ALIGN:
        begin
          if (!q.loopApplied)
          begin
            d.loop = LOOP_OPEN;
          end
          else if (alignDone)
          begin
            d.loop = LOOP_CLOSED; // [R8]
            d.aligned = 1'b1;
          end
        end
        LOOP_WAIT_INDEX:
        begin
          if (!q.loopApplied)
          begin
            d.loop = LOOP_OPEN;
          end
          else if (idxEdge)
          begin
            d.loop = LOOP_CLOSED; // [R9]
            d.aligned = 1'b1;
          end
        end
        LOOP_CLOSED:
        begin
          if (!q.loopApplied)
          begin
            d.loop = LOOP_OPEN; // [R3]
          end
        end
        default:
        begin
          d.loop = LOOP_OPEN;
        end
      endcase

      // Registered source numbers, 0 meaning none found
      d.pos = srchPos; // [R18]
      d.vel = srchVel; // [R18]
      d.comm = srchComm; // [R19]
    end
  end

  // State register
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      q <= '0;
      q.submode <= SUBMODE_RESET;
      q.mask <= {FB_COUNT{FB_MASK_RESET}};
      q.maskApplied <= {FB_COUNT{FB_MASK_RESET}};
      q.rebootCmd <= REBOOT_RESET;
      q.rebootDelay <= REBOOT_RESET;
      q.loop <= LOOP_OPEN;
    end
    else
    begin
      q <= d;
    end
  end

  // Outputs; mode bits gated by the live loop state where it matters
  assign odAck = q.ack;
  assign odAbort = q.abort;
  assign odRdData = q.rdData;
  assign firmwareReboot = q.rebootPulse; // [R1]
  assign rebootPending = q.rebootArmed;
  assign loopModeSelect = q.loopApplied; // [R3]
  assign closedLoopActive = (q.loop == LOOP_CLOSED);
  assign alignActive = (q.loop == LOOP_ALIGN); // [R8]
  assign rampSpeedEmulation = q.submode[SM_RAMP]; // [R5]
  assign autoBrakeEn = q.submode[SM_BRAKE]; // [R6]
  assign current_reduction_en = q.submode[SM_CURRENT_REDUCTION_EN] & (q.loop != LOOP_CLOSED); // [R7]
  assign torqueOnly = q.submode[SM_TORQUE] & torqueModeActive; // [R11]
  assign bldcMotor = q.submode[SM_BLDC]; // [R12]
  // Guarded here as well, since a master may set it too early
  assign slowSpeedEn = q.submode[SM_SLOW] & (q.loop == LOOP_CLOSED); // [R13]
  assign posSource = q.pos;
  assign velSource = q.vel;
  assign commSource = q.comm;

endmodule // drive_submode_feedback_select

`default_nettype wire

// ===== tb/drive_submode_feedback_properties.sv
// Port checker for the drive submode and feedback selection block.
// Bound into the top module; one clock, reset asynchronous active low.
`timescale 1ns/1ns
`default_nettype none
module drive_submode_feedback_properties
  import drive_cfg_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic odWrEn,
  input wire logic odRdEn,
  input wire logic [15:0] odIndex,
  input wire logic [7:0] odSubIndex,
  input wire logic [31:0] odWrData,
  input wire logic odAbort,
  input wire logic opEnabled,
  input wire logic firmwareReboot,
  input wire logic rebootPending,
  input wire logic loopModeSelect,
  input wire logic closedLoopActive,
  input wire logic current_reduction_en,
  input wire logic slowSpeedEn,
  input wire logic [2:0] posSource,
  input wire logic [2:0] commSource
);
  // A read in the same cycle cancels the write
  wire logic wrTaken = ce && odWrEn && !odRdEn;
  wire logic keyWr = wrTaken && odIndex == OBJ_REBOOT && odWrData == REBOOT_KEY
    && odSubIndex == SUB_REBOOT_CMD;
  wire logic countWr = wrTaken && odIndex == OBJ_FB_SEL && odSubIndex == SUB_COUNT;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  // Mode outputs are gated by the loop state of the same cycle, so no slack
  property p_countRo; countWr |=> odAbort; endproperty
  a_countRo: assert property (p_countRo) else $error("count write not refused");
  property p_keyArm; keyWr |=> rebootPending; endproperty
  a_keyArm: assert property (p_keyArm) else $error("key did not arm");
  property p_cause; firmwareReboot |-> $past(rebootPending); endproperty
  a_cause: assert property (p_cause) else $error("reboot without request");
  property p_hold; opEnabled |=> $stable(loopModeSelect); endproperty
  a_hold: assert property (p_hold) else $error("loop select moved");
  property p_slow; slowSpeedEn |-> closedLoopActive; endproperty
  a_slow: assert property (p_slow) else $error("slow speed in open loop");
  property p_red; current_reduction_en |-> !closedLoopActive; endproperty
  a_red: assert property (p_red) else $error("reduction in closed loop");
  property p_comm; !loopModeSelect [*3] |-> commSource == SENSOR_NONE; endproperty
  a_comm: assert property (p_comm) else $error("commutation in open loop");
  property p_first; posSource != 3'h1 && commSource != 3'h1; endproperty
  a_first: assert property (p_first) else $error("sensorless picked");
endmodule // drive_submode_feedback_properties
bind drive_submode_feedback_select drive_submode_feedback_properties chk (.*);
`default_nettype wire

// ===== tb/od_master.sv
// Dictionary master model: one access at a time, one-cycle strobe.
// The bench calls access() by hierarchy; mclk runs free.
`timescale 1ns/1ns
`default_nettype none
module od_master (
  input wire logic mclk,
  input wire logic odAck,
  input wire logic odAbort,
  input wire logic [31:0] odRdData,
  output logic odWrEn,
  output logic odRdEn,
  output logic [15:0] odIndex,
  output logic [7:0] odSubIndex,
  output logic [31:0] odWrData
);
  initial
  begin
    {odWrEn, odRdEn, odIndex, odSubIndex, odWrData} = 58'h0;
  end
  // A held strobe would be a second access; released lines show the
  // inverse so a late sample cannot pass by luck
  task automatic access(input logic w, input logic [15:0] i, input logic [7:0] s,
    input logic [31:0] d, output logic [31:0] rd, output logic [1:0] rsp);
    @(posedge mclk);
    {odWrEn, odRdEn, odIndex, odSubIndex, odWrData} <= {w, !w, i, s, d};
    @(posedge mclk);
    {odWrEn, odRdEn, odIndex, odSubIndex, odWrData} <= {2'h0, ~i, ~s, ~d};
    #1 rd = odRdData;
    rsp = {odAck, odAbort};
  endtask
endmodule // od_master
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench for the drive submode and feedback selection block.
// Dictionary traffic goes through the master model; mclk is 125 MHz.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import drive_cfg_pkg::*;
  localparam logic WR = 1'h1, RD = 1'h0;
  localparam logic [1:0] OK = 2'h2, AB = 2'h1;
  logic mclk, rst_b = 1'h0, ce = 1'h1, opEnabled = 1'h0, torqueModeActive = 1'h0;
  logic commNoIndex = 1'h0, alignDone = 1'h0, encIndexPin = 1'h0;
  logic odWrEn, odRdEn, odAck, odAbort, firmwareReboot, rebootPending, loopModeSelect;
  logic closedLoopActive, alignActive, rampSpeedEmulation, autoBrakeEn, torqueOnly;
  logic current_reduction_en, bldcMotor, slowSpeedEn;
  logic [15:0] odIndex;
  logic [7:0] odSubIndex;
  logic [31:0] odWrData, odRdData, rdv;
  logic [2:0] posSource, velSource, commSource;
  logic [1:0] rsp;
  int errCount = 0, cmpCount = 0, cycles = 0;
  // A millisecond of 4 cycles keeps reboot delays short
  drive_submode_feedback_select #(.CYCLES_PER_MS_P(4)) DUT (.*);
  od_master master (.*);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp)
    begin
      errCount++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One access; the answer code is {ack, abort}
  task automatic acc(input logic w, input logic [15:0] i, input logic [7:0] s,
    input logic [31:0] d, input logic [1:0] exp);
    master.access(w, i, s, d, rdv, rsp);
    check(rsp, exp);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic endSim();
    $display("compares %0d mismatches %0d", cmpCount, errCount);
    if (errCount == 0 && cmpCount > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Reset values, the read-only count entry and an unmapped index
  task automatic tRegs();
    acc(RD, OBJ_SUBMODE, 8'h0, 32'h0, OK);
    check(rdv, SUBMODE_RESET);
    for (int i = 1; i < 4; i++)
    begin
      acc(RD, OBJ_FB_SEL, 8'(i), 32'h0, OK);
      check(rdv, 32'h0);
    end
    acc(WR, OBJ_FB_SEL, SUB_COUNT, 32'h5, AB);
    acc(RD, OBJ_FB_SEL, SUB_COUNT, 32'h0, OK);
    check(rdv, 32'h3);
    acc(RD, 16'h3201, 8'h0, 32'h0, AB);
    // With ce low a write is not taken and no answer comes back
    @(posedge mclk);
    ce <= 1'h0;
    acc(WR, OBJ_SUBMODE, 8'h0, 32'h5a, 2'h0);
    @(posedge mclk);
    ce <= 1'h1;
    acc(RD, OBJ_SUBMODE, 8'h0, 32'h0, OK);
    check(rdv, SUBMODE_RESET);
  endtask
  // Submode bits 1, 2, 3, 5 and 6, plus undefined high bits
  task automatic tSubmode();
    @(posedge mclk);
    torqueModeActive <= 1'h1;
    acc(WR, OBJ_SUBMODE, 8'h0, 32'ha5a5006e, OK);
    acc(RD, OBJ_SUBMODE, 8'h0, 32'h0, OK);
    check(rdv, 32'ha5a5006e);
    check({rampSpeedEmulation, autoBrakeEn, bldcMotor}, 3'h7);
    check({current_reduction_en, torqueOnly, slowSpeedEn}, 3'h6);
    @(posedge mclk);
    torqueModeActive <= 1'h0;
    #1 check(torqueOnly, 1'h0);
    acc(WR, OBJ_SUBMODE, 8'h0, 32'h0, OK);
  endtask
  // A near-miss key must not arm; the real one fires after two milliseconds
  task automatic tReboot();
    int n = 0;
    acc(WR, OBJ_REBOOT, SUB_REBOOT_DELAY, 32'h2, OK);
    acc(WR, OBJ_REBOOT, SUB_REBOOT_CMD, 32'h746f6f63, OK);
    check(rebootPending, 1'h0);
    acc(WR, OBJ_REBOOT, SUB_REBOOT_CMD, REBOOT_KEY, OK);
    check(rebootPending, 1'h1);
    while (firmwareReboot !== 1'h1 && n < 40)
    begin
      @(posedge mclk);
      #1 n++;
    end
    check(n >= 8 && n <= 10, 1'h1);
    @(posedge mclk);
    #1 check({firmwareReboot, rebootPending}, 2'h0);
  endtask
  // Fresh reset, closed loop asked for, alignment must run before closing
  task automatic alignRun(input logic noIdx, input logic [31:0] mode);
    @(posedge mclk);
    rst_b <= 1'h0;
    cyc(2);
    rst_b <= 1'h1;
    commNoIndex <= noIdx;
    acc(WR, OBJ_SUBMODE, 8'h0, mode, OK);
    cyc(3);
    #1 check({alignActive, closedLoopActive}, 2'h2);
    @(posedge mclk);
    alignDone <= 1'h1;
    cyc(2);
    alignDone <= 1'h0;
    #1 check({alignActive, closedLoopActive}, 2'h1);
  endtask
  // Index path, both alignment paths, then the enabled-state freeze
  task automatic tLoop();
    acc(WR, OBJ_SUBMODE, 8'h0, 32'h1, OK);
    cyc(20);
    #1 check({loopModeSelect, closedLoopActive, alignActive}, 3'h4);
    @(posedge mclk);
    encIndexPin <= 1'h1;
    cyc(8);
    encIndexPin <= 1'h0;
    #1 check(closedLoopActive, 1'h1);
    alignRun(1'h0, 32'h11);
    alignRun(1'h1, 32'h1);
    @(posedge mclk);
    opEnabled <= 1'h1;
    acc(WR, OBJ_SUBMODE, 8'h0, 32'h80, OK);
    cyc(3);
    #1 check({loopModeSelect, closedLoopActive, slowSpeedEn}, 3'h7);
    @(posedge mclk);
    opEnabled <= 1'h0;
    cyc(4);
    #1 check({loopModeSelect, closedLoopActive, slowSpeedEn}, 3'h0);
  endtask
  // Masks take effect only on entry to operation enabled
  task automatic tFeedback();
    acc(WR, OBJ_SUBMODE, 8'h0, 32'h1, OK);
    acc(WR, OBJ_FB_SEL, 8'h1, 32'hffffff07, OK);
    acc(WR, OBJ_FB_SEL, 8'h2, 32'h2, OK);
    acc(WR, OBJ_FB_SEL, 8'h3, 32'h5, OK);
    #1 check({posSource, velSource, commSource}, 9'h0);
    @(posedge mclk);
    opEnabled <= 1'h1;
    cyc(4);
    #1 check({posSource, velSource, commSource}, {3'h3, 3'h2, 3'h3});
    acc(WR, OBJ_FB_SEL, 8'h2, 32'h7, OK);
    cyc(3);
    #1 check({posSource, velSource, commSource}, {3'h3, 3'h2, 3'h3});
    acc(RD, OBJ_FB_SEL, 8'h1, 32'h0, OK);
    check(rdv, 32'h7);
    @(posedge mclk);
    opEnabled <= 1'h0;
    acc(WR, OBJ_SUBMODE, 8'h0, 32'h0, OK);
    cyc(2);
    opEnabled <= 1'h1;
    cyc(4);
    #1 check({posSource, velSource, commSource}, {3'h2, 3'h2, 3'h0});
  endtask
  initial
  begin
    mclk = 1'h0;
    forever #4 mclk = ~mclk;
  end
  // Ceiling far above the roughly 140 cycles the scenarios need
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      errCount++;
      endSim();
    end
  end
  initial
  begin
    cyc(4);
    rst_b <= 1'h1;
    tRegs();
    tSubmode();
    tReboot();
    tLoop();
    tFeedback();
    endSim();
  end
endmodule // testbench
`default_nettype wire
